// *** design/lct_regs.svh ***
// Purpose: constants of the lcd clock/timer control block
// Assumes: 8-bit serial bit addresses, millisecond time base
// Notes: definitions only
`ifndef LCT_REGS_SVH
`define LCT_REGS_SVH
`define LCT_CLK_NS 100
`define LCT_TICK_NS 1000000
`define LCT_DOT_LAST 8'h7F
`define LCT_CLK_FIRST 8'hC0
`define LCT_CLK_LAST 8'hE3
`define LCT_CTL_FIRST 8'hF8
`define LCT_CTL_DCLR 4
`define LCT_CTL_RDOE 5
`define LCT_CTL_TIMER 6
`define LCT_CTL_CLOCK 7
`define LCT_POR_TIME 36'h000000101
`define LCT_SEC_LAST 6'h3B
`define LCT_MIN_LAST 8'h59
`define LCT_HOUR_LAST 8'h23
`define LCT_MON_LAST 8'h12
`define LCT_ONE 8'h01
`define LCT_FEB 8'h02
`define LCT_DAYS_28 8'h28
`define LCT_DAYS_29 8'h29
`define LCT_DAYS_30 8'h30
`define LCT_DAYS_31 8'h31
`define LCT_LEAP_LAST 4'h3
`define LCT_TH_LAST 4'hB
`define LCT_SEC_MS 15'd1000
`define LCT_DEB_MS 15'd35
`define LCT_QSET_MS 15'd2000
`define LCT_QREP_MS 15'd125
`define LCT_IDLE_MS 15'd6000
`define LCT_HOLD_MS 15'd5000
`define LCT_RET_MS 15'd15000
`define LCT_RET_LONG_MS 15'd30000
`define LCT_FLASH_MS 15'd2000
`define LCT_REG_CTRL 8'h00
`define LCT_REG_STATUS 8'h04
`define LCT_REG_TIME 8'h08
`define LCT_REG_TIMER 8'h0C
`endif

// *** design/lct_pkg.sv ***
// Purpose: types of the lcd clock/timer control block
// Assumes: nothing
// Notes: constants live in lct_regs.svh
`default_nettype none
package lct_pkg;
    typedef enum logic [1:0] {DISP_CLOCK = 2'b00, DISP_NORMAL = 2'b01,
        DISP_TIMER = 2'b10, DISP_FLASH = 2'b11} lct_disp_t;
    typedef enum logic [2:0] {ADJ_IDLE = 3'b000, ADJ_MON = 3'b001, ADJ_DATE = 3'b010,
        ADJ_HOUR = 3'b011, ADJ_MIN = 3'b100, ADJ_LEAP = 3'b101} lct_adj_t;
    typedef struct packed {logic wclk; logic wdata; logic rclk;} lct_link_t;
    typedef struct packed {logic mode; logic set; logic toggle;} lct_btn_t;
    typedef struct packed {
        logic wclk; logic wdata; logic rclk; logic cas; logic inh; logic hfmt; logic rstn;
    } lct_pins_t;
    typedef struct packed {
        logic [3:0] leap; logic [7:0] min; logic [7:0] hour; logic [7:0] date; logic [7:0] mon;
    } lct_time_t;
endpackage
`default_nettype wire

// *** design/lct_dot_mem.sv ***
// Purpose: dot storage with registered single-bit read
// Assumes: clear is a level
// Notes: async reset clears all dots
`timescale 1ns/1ps
`default_nettype none
module lct_dot_mem #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    // clock
    input wire logic hclk,
    input wire logic hresetn,
    // access
    input wire logic clr,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic wbit,
    input wire logic [AW-1:0] raddr,
    output logic rbit
);
    typedef struct packed {logic [DEPTH-1:0] bits; logic rd;} lct_mem_t;
    lct_mem_t st, nx;
    if (DEPTH != (1 << AW)) $error("depth must equal two to the address width");
    always_comb begin
        nx = st;
        if (clr) nx.bits = '0;
        else if (we) nx.bits[waddr] = wbit;
        nx.rd = st.bits[raddr];
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end
    assign rbit = st.rd;
endmodule
`default_nettype wire

// *** design/lct_debounce.sv ***
// Purpose: two-stage synchroniser and debouncer of one button
// Assumes: tick is a one-cycle millisecond pulse
// Notes: level changes after DEB_TICKS stable ticks
`timescale 1ns/1ps
`default_nettype none
`include "lct_regs.svh"
module lct_debounce #(
    parameter logic [14:0] DEB_TICKS = `LCT_DEB_MS
) (
    // clock
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    // button
    input wire logic din,
    output logic dout
);
    typedef struct packed {logic s1; logic s2; logic lvl; logic [14:0] cnt;} lct_deb_t;
    lct_deb_t st, nx;
    if (DEB_TICKS == '0) $error("debounce count must be positive");
    always_comb begin
        nx = st;
        nx.s1 = din;
        nx.s2 = st.s1;
        if (st.s2 == st.lvl) nx.cnt = '0;
        else if (tick) begin
            nx.cnt = st.cnt + 15'h0001;
            if (nx.cnt >= DEB_TICKS) begin
                nx.lvl = st.s2;
                nx.cnt = '0;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end
    assign dout = st.lvl;
endmodule
`default_nettype wire

// *** design/lct_top.sv ***
// Purpose: serial link, calendar clock, call timer and resets of the lcd driver
// Assumes: link pins idle high, at least two hclk cycles per link clock phase
// Notes: Contract
// Contract
// - eight address bits, lsb first, then data
// - one bit stored per write clock, address advances
// - rclk fall enters read, rise shifts bit out
// - dots writable only with select high
// - dot addresses 0..127 wrap to zero
// - timer and clock bits at 254, 255
// - clock writable at 192..227 when allowed
// - clock write stops time, read restarts
// - four-bit digits: month, date, hour fields
// - 24-hour storage, 12-hour display by pin
// - leap counter at 224..227, zero is leap
// - mode steps fields, set increments field
// - 15 or 30 s without mode returns
// - set held 2 s repeats every 125 ms
// - timer needs inhibit low, select high, bit zero
// - 6 s idle starts timer, 5 s hold
// - timer wraps 11-59-59 to 00-00-00
// - toggle pin inverts timer run state
// - power-on: flash, time 1-1 00:00, dots cleared
// - reset pin: all but clock reset, flash
`timescale 1ns/1ps
`default_nettype none
`include "lct_regs.svh"
module lct_top import lct_pkg::*; #(
    parameter int TICK_CYCLES = `LCT_TICK_NS / `LCT_CLK_NS
) (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // serial link
    input wire lct_link_t link,
    output logic rdata_o,
    output logic rdata_oe,
    // pins
    input wire logic chip_active_select,
    input wire logic timer_inhibit_n,
    input wire logic hour_format,
    input wire logic rst_pin_n,
    input wire lct_btn_t btn,
    // display state
    output lct_disp_t disp_mode,
    output lct_adj_t adj_field,
    output logic [7:0] hour_disp,
    output logic pm_ind
);
    localparam int TW = $clog2(TICK_CYCLES);
    localparam lct_pins_t PINS_IDLE = '{wclk: 1'b1, wdata: 1'b0, rclk: 1'b1, cas: 1'b0,
        inh: 1'b0, hfmt: 1'b0, rstn: 1'b1};
    if (TICK_CYCLES < 2) $error("tick divider must be at least two");

    typedef struct packed {
        lct_pins_t s1; lct_pins_t s2; lct_pins_t p;
        logic [TW-1:0] tck; logic [14:0] ms;
        logic rd_mode; logic aph; logic [2:0] bitn; logic [7:0] addr; logic [7:0] ctl;
        logic rdata;
        lct_time_t tm; logic [5:0] sec; logic stop; logic [14:0] flash;
        lct_adj_t adj; logic [14:0] ret; logic [14:0] hold; logic [14:0] rep;
        logic [2:0] bp;
        logic trun; logic tauto; logic [3:0] th; logic [5:0] tmn; logic [5:0] tsc;
        logic [14:0] tidle; logic [14:0] thold;
        logic long_ret; logic dph; logic dwr; logic [7:0] da; logic [31:0] hrd;
        lct_disp_t disp; logic [7:0] hdisp; logic pm;
    } lct_st_t;
    lct_st_t st, nx;

    // ========================================
    // helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
        input logic [7:0] hi);
        if (v >= hi) bcd_inc = lo;
        else if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else bcd_inc = v + 8'h01;
    endfunction

    function automatic logic [3:0] lp_inc(input logic [3:0] v);
        lp_inc = (v >= `LCT_LEAP_LAST) ? 4'h0 : v + 4'h1;
    endfunction

    function automatic logic [7:0] dim(input logic [7:0] m, input logic [3:0] lp);
        if (m == `LCT_FEB) dim = (lp == 4'h0) ? `LCT_DAYS_29 : `LCT_DAYS_28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) dim = `LCT_DAYS_30;
        else dim = `LCT_DAYS_31;
    endfunction

    function automatic logic in_clk(input logic [7:0] a);
        in_clk = a >= `LCT_CLK_FIRST && a <= `LCT_CLK_LAST;
    endfunction

    function automatic logic [7:0] adv(input logic [7:0] a);
        adv = (a == `LCT_DOT_LAST) ? 8'h00 : a + 8'h01;
    endfunction

    function automatic logic [8:0] hr12(input logic [7:0] h);
        logic [4:0] b;
        b = 5'(h[5:4]) * 5'h0A + 5'(h[3:0]);
        hr12[8] = b >= 5'h0C;
        if (hr12[8]) b = b - 5'h0C;
        if (b == 5'h00) b = 5'h0C;
        hr12[7:0] = (b >= 5'h0A) ? {4'h1, 4'(b - 5'h0A)} : {4'h0, b[3:0]};
    endfunction

    // ========================================
    // buttons
    logic [2:0] braw, blv;
    lct_btn_t brise, bl;
    logic tick;
    assign braw = btn;
    for (genvar i = 0; i < 3; i++) begin : g_deb
        lct_debounce u_deb (
            .hclk(hclk),
            .hresetn(hresetn),
            .tick(tick),
            .din(braw[i]),
            .dout(blv[i])
        );
    end

    // ========================================
    // dot memory
    logic mem_we, mem_clr, rbit;
    lct_dot_mem u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(mem_clr),
        .we(mem_we),
        .waddr(st.addr[6:0]),
        .wbit(st.s2.wdata),
        .raddr(st.addr[6:0]),
        .rbit(rbit)
    );

    // ========================================
    // next state
    logic sec_t, wr_ev, rr_ev, rf_ev, cas_r, cas_f, prst, tok, wr_dat, sinc;
    logic [7:0] a8, ia;
    logic [2:0] bn;
    always_comb begin
        nx = st;
        nx.s1 = '{link.wclk, link.wdata, link.rclk, chip_active_select, timer_inhibit_n,
            hour_format, rst_pin_n};
        nx.s2 = st.s1;
        nx.p = st.s2;
        bl = lct_btn_t'(blv);
        brise = lct_btn_t'(blv & ~st.bp);
        nx.bp = blv;
        tick = st.tck == TW'(TICK_CYCLES - 1);
        nx.tck = tick ? '0 : st.tck + 1'b1;
        sec_t = tick && st.ms == `LCT_SEC_MS - 15'd1;
        if (tick) nx.ms = sec_t ? '0 : st.ms + 15'h0001;
        wr_ev = st.s2.wclk & ~st.p.wclk;
        rr_ev = st.s2.rclk & ~st.p.rclk;
        rf_ev = ~st.s2.rclk & st.p.rclk;
        cas_r = st.s2.cas & ~st.p.cas;
        cas_f = ~st.s2.cas & st.p.cas;
        prst = ~st.s2.rstn;
        tok = ~st.s2.inh & st.s2.cas & ~st.ctl[`LCT_CTL_TIMER];
        wr_dat = wr_ev && !st.rd_mode && !st.aph;
        mem_we = 1'b0;
        mem_clr = prst | st.ctl[`LCT_CTL_DCLR];
        ia = st.addr - `LCT_CLK_FIRST;
        a8 = st.rd_mode ? 8'h00 : st.addr;
        bn = st.rd_mode ? 3'h0 : st.bitn;
        sinc = 1'b0;
        // serial link
        if (rf_ev) begin
            nx.rd_mode = 1'b1;
            nx.stop = 1'b0;
            if (st.stop) nx.sec = '0;
        end
        if (rr_ev && st.rd_mode) begin
            if (st.addr <= `LCT_DOT_LAST) nx.rdata = rbit;
            else if (in_clk(st.addr)) nx.rdata = st.tm[ia[5:0]];
            else if (st.addr >= `LCT_CTL_FIRST) nx.rdata = st.ctl[st.addr[2:0]];
            else nx.rdata = 1'b0;
            nx.addr = adv(st.addr);
        end
        if (wr_ev) begin
            nx.rd_mode = 1'b0;
            if (st.rd_mode || st.aph) begin
                a8[bn] = st.s2.wdata;
                nx.addr = a8;
                nx.bitn = bn + 3'h1;
                nx.aph = bn != 3'h7;
            end else begin
                if (st.addr <= `LCT_DOT_LAST) mem_we = st.s2.cas;
                else if (in_clk(st.addr) && st.s2.cas && !st.ctl[`LCT_CTL_CLOCK]) begin
                    nx.tm[ia[5:0]] = st.s2.wdata;
                    nx.stop = 1'b1;
                end else if (st.addr >= `LCT_CTL_FIRST) begin
                    nx.ctl[st.addr[2:0]] = st.s2.wdata;
                end
                nx.addr = adv(st.addr);
            end
        end
        // calendar
        if (sec_t && !st.stop) begin
            nx.sec = st.sec + 6'h01;
            if (st.sec == `LCT_SEC_LAST) begin
                nx.sec = '0;
                nx.tm.min = bcd_inc(st.tm.min, 8'h00, `LCT_MIN_LAST);
                if (st.tm.min == `LCT_MIN_LAST) begin
                    nx.tm.hour = bcd_inc(st.tm.hour, 8'h00, `LCT_HOUR_LAST);
                    if (st.tm.hour == `LCT_HOUR_LAST) begin
                        nx.tm.date = bcd_inc(st.tm.date, `LCT_ONE, dim(st.tm.mon, st.tm.leap));
                        if (st.tm.date == dim(st.tm.mon, st.tm.leap)) begin
                            nx.tm.mon = bcd_inc(st.tm.mon, `LCT_ONE, `LCT_MON_LAST);
                            if (st.tm.mon == `LCT_MON_LAST) nx.tm.leap = lp_inc(st.tm.leap);
                        end
                    end
                end
            end
        end
        // manual adjustment
        if (!bl.set) begin
            nx.hold = '0;
            nx.rep = '0;
        end else if (tick) begin
            if (st.hold < `LCT_QSET_MS) nx.hold = st.hold + 15'h0001;
            else nx.rep = (st.rep == `LCT_QREP_MS - 15'd1) ? '0 : st.rep + 15'h0001;
            sinc = st.hold == `LCT_QSET_MS && st.rep == `LCT_QREP_MS - 15'd1;
        end
        if (st.disp != DISP_CLOCK) begin
            nx.adj = ADJ_IDLE;
            nx.ret = '0;
        end else begin
            if (tick && st.adj != ADJ_IDLE) nx.ret = st.ret + 15'h0001;
            if (brise.mode) begin
                nx.ret = '0;
                case (st.adj)
                    ADJ_IDLE: nx.adj = ADJ_MON;
                    ADJ_MON: nx.adj = ADJ_DATE;
                    ADJ_DATE: nx.adj = ADJ_HOUR;
                    ADJ_HOUR: nx.adj = ADJ_MIN;
                    ADJ_MIN: nx.adj = ADJ_LEAP;
                    default: nx.adj = ADJ_IDLE;
                endcase
            end else if (st.ret >= (st.long_ret ? `LCT_RET_LONG_MS : `LCT_RET_MS)) begin
                nx.adj = ADJ_IDLE;
                nx.ret = '0;
            end else if (brise.set || sinc) begin
                if (st.adj != ADJ_IDLE) nx.sec = '0;
                case (st.adj)
                    ADJ_MON: nx.tm.mon = bcd_inc(st.tm.mon, `LCT_ONE, `LCT_MON_LAST);
                    ADJ_DATE: nx.tm.date = bcd_inc(st.tm.date, `LCT_ONE,
                        dim(st.tm.mon, st.tm.leap));
                    ADJ_HOUR: nx.tm.hour = bcd_inc(st.tm.hour, 8'h00, `LCT_HOUR_LAST);
                    ADJ_MIN: nx.tm.min = bcd_inc(st.tm.min, 8'h00, `LCT_MIN_LAST);
                    ADJ_LEAP: nx.tm.leap = lp_inc(st.tm.leap);
                    default: nx.tm = st.tm;
                endcase
            end
        end
        // call timer
        if (wr_ev || rr_ev || rf_ev || cas_r) nx.tidle = '0;
        else if (tick && st.s2.cas && st.tidle < `LCT_IDLE_MS) nx.tidle = st.tidle + 15'h0001;
        if (!tok) nx.trun = 1'b0;
        else if (brise.toggle) nx.trun = ~st.trun;
        else if (!st.tauto && st.tidle >= `LCT_IDLE_MS) begin
            nx.trun = 1'b1;
            nx.tauto = 1'b1;
        end
        if (sec_t && st.trun) begin
            nx.tsc = (st.tsc == `LCT_SEC_LAST) ? '0 : st.tsc + 6'h01;
            if (st.tsc == `LCT_SEC_LAST) begin
                nx.tmn = (st.tmn == `LCT_SEC_LAST) ? '0 : st.tmn + 6'h01;
                if (st.tmn == `LCT_SEC_LAST) nx.th = (st.th == `LCT_TH_LAST) ? '0 : st.th + 4'h1;
            end
        end
        if (cas_f && !st.s2.inh && !st.ctl[`LCT_CTL_TIMER]) nx.thold = `LCT_HOLD_MS;
        else if (tick && st.thold != '0) nx.thold = st.thold - 15'h0001;
        if (cas_r) begin
            nx.th = '0;
            nx.tmn = '0;
            nx.tsc = '0;
            nx.trun = 1'b0;
            nx.tauto = 1'b0;
        end
        if (tick && st.flash != '0) nx.flash = st.flash - 15'h0001;
        // reset pin spares the calendar
        if (prst) begin
            nx.rd_mode = 1'b0;
            nx.aph = 1'b1;
            nx.bitn = '0;
            nx.ctl = '0;
            nx.adj = ADJ_IDLE;
            nx.trun = 1'b0;
            nx.tauto = 1'b0;
            nx.th = '0;
            nx.tmn = '0;
            nx.tsc = '0;
            nx.thold = '0;
            nx.tidle = '0;
            nx.long_ret = 1'b0;
            nx.flash = `LCT_FLASH_MS;
        end
        // display selection
        if (st.flash != '0) nx.disp = DISP_FLASH;
        else if (st.thold != '0) nx.disp = DISP_TIMER;
        else if (st.s2.cas) nx.disp = tok ? DISP_TIMER : DISP_NORMAL;
        else if (!st.ctl[`LCT_CTL_CLOCK]) nx.disp = DISP_CLOCK;
        else if (st.ctl[`LCT_CTL_TIMER]) nx.disp = DISP_NORMAL;
        else nx.disp = DISP_TIMER;
        {nx.pm, nx.hdisp} = st.s2.hfmt ? hr12(st.tm.hour) : {1'b0, st.tm.hour};
        // register bus
        if (st.dph && st.dwr && st.da == `LCT_REG_CTRL) nx.long_ret = hwdata[0];
        nx.dph = hsel && htrans[1] && hready;
        if (nx.dph) begin
            nx.dwr = hwrite;
            nx.da = haddr[7:0];
            case (haddr[7:0])
                `LCT_REG_CTRL: nx.hrd = {31'h0, nx.long_ret};
                `LCT_REG_STATUS: nx.hrd = {24'h0, st.stop, st.rd_mode, st.trun, st.adj, st.disp};
                `LCT_REG_TIME: nx.hrd = st.tm[31:0];
                `LCT_REG_TIMER: nx.hrd = {12'h0, st.tm.leap, st.th, st.tmn, st.tsc};
                default: nx.hrd = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.s1 <= PINS_IDLE;
            st.s2 <= PINS_IDLE;
            st.p <= PINS_IDLE;
            st.aph <= 1'b1;
            st.tm <= `LCT_POR_TIME;
            st.flash <= `LCT_FLASH_MS;
            st.disp <= DISP_FLASH;
        end else begin
            st <= nx;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.hrd;
    assign rdata_o = st.rdata;
    assign rdata_oe = st.rd_mode & st.ctl[`LCT_CTL_RDOE];
    assign disp_mode = st.disp;
    assign adj_field = st.adj;
    assign hour_disp = st.hdisp;
    assign pm_ind = st.pm;

    // ========================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_last_addr_bit;
        wr_ev && !st.rd_mode && st.aph && st.bitn == 3'h7 && !prst;
    endsequence
    property p_addr_done;
        s_last_addr_bit |=> !st.aph && st.addr[7] == $past(st.s2.wdata);
    endproperty
    a_addr_done: assert property (p_addr_done) else $error("address phase end");
    property p_dot_step;
        wr_dat && st.addr < `LCT_DOT_LAST |=> st.addr == $past(st.addr) + 8'h01;
    endproperty
    a_dot_step: assert property (p_dot_step) else $error("address not advanced");
    property p_wrap;
        wr_dat && st.addr == `LCT_DOT_LAST |=> st.addr == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("dot address did not wrap");
    property p_rd_sw;
        rf_ev && !prst |=> st.rd_mode ##1 st.rd_mode || $past(wr_ev);
    endproperty
    a_rd_sw: assert property (p_rd_sw) else $error("read mode not entered");
    property p_oe;
        rf_ev && !prst && st.ctl[`LCT_CTL_RDOE] |=> rdata_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("read pin not driven");
    property p_dot_guard;
        wr_dat && st.addr <= `LCT_DOT_LAST && !st.s2.cas && !mem_clr |=>
            u_mem.st.bits == $past(u_mem.st.bits);
    endproperty
    a_dot_guard: assert property (p_dot_guard) else $error("dot written unselected");
    property p_clk_guard;
        wr_dat && in_clk(st.addr) && st.ctl[`LCT_CTL_CLOCK] && !sec_t |=>
            st.tm == $past(st.tm);
    endproperty
    a_clk_guard: assert property (p_clk_guard) else $error("clock written locked");
    property p_restart;
        st.stop && rf_ev |=> !st.stop [*2];
    endproperty
    a_restart: assert property (p_restart) else $error("clock did not restart");
    property p_inhibit;
        st.s2.inh |=> !st.trun;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("timer ran inhibited");
    property p_twrap;
        sec_t && st.trun && !cas_r && !prst && st.th == `LCT_TH_LAST
            && st.tmn == `LCT_SEC_LAST && st.tsc == `LCT_SEC_LAST
            |=> st.th == 4'h0 && st.tmn == 6'h00 && st.tsc == 6'h00;
    endproperty
    a_twrap: assert property (p_twrap) else $error("timer did not wrap");
    property p_pin_rst;
        prst |=> st.flash == `LCT_FLASH_MS && st.adj == ADJ_IDLE && !st.trun;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin reset incomplete");
endmodule
`default_nettype wire

// *** dv/lct_host_model.sv ***
// Purpose: serial link host model
// Assumes: 800 ns link period
// Notes: undriven read pin shows inverted data
`timescale 1ns/1ps
`default_nettype none
module lct_host_model import lct_pkg::*; (
    // clock
    input wire logic hclk,
    // link
    output var lct_link_t link,
    input wire logic rdata_o,
    input wire logic rdata_oe
);
    wire logic pin = rdata_oe ? rdata_o : ~rdata_o;
    initial link = 3'b111;
    task automatic ph();
        repeat (4) @(posedge hclk);
    endtask
    // dummy read, then address lsb first, then data
    task automatic send(input logic [7:0] a, input int n, input logic [15:0] d);
        link.rclk <= 1'b0;
        ph();
        link.rclk <= 1'b1;
        ph();
        for (int i = 0; i < 8 + n; i++) begin
            link.wdata <= (i < 8) ? a[i] : d[i - 8];
            link.wclk <= 1'b0;
            ph();
            link.wclk <= 1'b1;
            ph();
        end
    endtask
    // bit 253 must be set by caller before this
    task automatic recv(input logic [7:0] a, input int n, output logic [15:0] q);
        q = '0;
        send(a, 0, '0);
        for (int i = 0; i <= n; i++) begin
            link.rclk <= 1'b0;
            ph();
            if (i > 0) q[i - 1] = pin;
            link.rclk <= 1'b1;
            ph();
        end
    endtask
endmodule
`default_nettype wire

// *** dv/lct_clock_timer_control_tb.sv ***
// Purpose: bench of the lcd clock/timer control block
// Assumes: tick of 4 hclk cycles
// Notes: serial traffic through the host model
`timescale 1ns/1ps
`default_nettype none
module lcd_clock_timer_control_tb import lct_pkg::*;;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cas = 0, hfmt = 0;
    logic pin_rst_n = 1, tim_inh_n = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, rdata_o, rdata_oe, pm_ind;
    logic [15:0] q;
    logic [7:0] hour_disp;
    lct_link_t link;
    lct_btn_t btn = '0;
    lct_disp_t disp_mode;
    lct_adj_t adj_field;
    int fail_count = 0, n_tests = 0;
    initial forever #50 hclk = ~hclk;
    lct_top #(.TICK_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .link(link), .rdata_o(rdata_o), .rdata_oe(rdata_oe), .chip_active_select(cas),
        .timer_inhibit_n(tim_inh_n), .hour_format(hfmt), .rst_pin_n(pin_rst_n), .btn(btn),
        .disp_mode(disp_mode), .adj_field(adj_field), .hour_disp(hour_disp),
        .pm_ind(pm_ind));
    lct_host_model host (.hclk(hclk), .link(link), .rdata_o(rdata_o), .rdata_oe(rdata_oe));
    // ==========
    // tasks
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s exp %h got %h", nm, exp, got);
            fail_count++;
        end
    endtask
    task automatic wait_rdy();
        int k;
        for (k = 0; k < 100; k++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (k == 100) begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= 0;
        wait_rdy();
        htrans <= 2'b00;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= 1;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic press(input int b);
        btn[b] <= 1'b1;
        repeat (200) @(posedge hclk);
        btn[b] <= 1'b0;
        repeat (200) @(posedge hclk);
    endtask
    task automatic t_reset();
        chk("disp", disp_mode, DISP_FLASH);
        rd(32'h8);
        chk("time", r, 32'h0000_0101);
        rd(32'h10);
        chk("unmapped", r, 32'h0);
        chk("hresp", hresp, 32'h0);
        wr(32'h0, 32'h1);
        rd(32'h0);
        chk("ctrl", r, 32'h1);
        $display("t_reset done");
    endtask
    task automatic t_dots();
        cas <= 1;
        host.send(8'hFD, 1, 16'h1);
        host.send(8'h7F, 2, 16'h3); // bits at 127 and wrapped 0
        host.recv(8'h7F, 2, q);
        chk("dots", q[1:0], 2'b11);
        chk("oe", rdata_oe, 1'b1);
        cas <= 0;
        host.send(8'h00, 1, 16'h0);
        host.recv(8'h00, 1, q);
        chk("dot_locked", q[0], 1'b1);
        $display("t_dots done");
    endtask
    task automatic t_clock();
        cas <= 1;
        host.send(8'hC0, 8, 16'h12);
        host.recv(8'hC0, 8, q);
        chk("mon_rd", q[7:0], 8'h12);
        rd(32'h8);
        chk("mon", r[7:0], 8'h12);
        host.send(8'hFF, 1, 16'h1);
        host.send(8'hC0, 8, 16'h05);
        host.recv(8'hC0, 8, q);
        chk("mon_locked", q[7:0], 8'h12);
        $display("t_clock done");
    endtask
    task automatic t_adjust();
        int k;
        cas <= 0;
        host.send(8'hFF, 1, 16'h0);
        for (k = 0; k < 10000 && disp_mode !== DISP_CLOCK; k++) @(posedge hclk);
        if (k == 10000) begin
            fail_count++;
            summarize();
        end
        chk("hour24", hour_disp, 8'h00);
        hfmt <= 1;
        repeat (4) @(posedge hclk);
        chk("hour12", hour_disp, 8'h12);
        chk("pm", pm_ind, 1'b0);
        hfmt <= 0;
        press(2);
        chk("adj", adj_field, ADJ_MON);
        press(1);
        rd(32'h8);
        chk("mon_set", r[7:0], 8'h01);
        $display("t_adjust done");
    endtask
    task automatic t_pinrst();
        pin_rst_n <= 0;
        repeat (6) @(posedge hclk);
        pin_rst_n <= 1;
        repeat (4) @(posedge hclk);
        chk("rst_disp", disp_mode, DISP_FLASH);
        chk("rst_adj", adj_field, ADJ_IDLE);
        rd(32'h0);
        chk("rst_ctrl", r, 32'h0);
        host.send(8'hFD, 1, 16'h1);
        host.recv(8'h7F, 2, q);
        chk("rst_dots", q[1:0], 2'b00);
        rd(32'h8);
        chk("rst_mon", r[7:0], 8'h01);
        $display("t_pinrst done");
    endtask
    task automatic t_timer();
        cas <= 1;
        tim_inh_n <= 0;
        press(0);
        rd(32'h4);
        chk("trun", r[5], 1'b1);
        tim_inh_n <= 1;
        repeat (4) @(posedge hclk);
        rd(32'h4);
        chk("inhibit", r[5], 1'b0);
        $display("t_timer done");
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        t_reset();
        t_dots();
        t_clock();
        t_adjust();
        t_pinrst();
        t_timer();
        summarize();
    end
endmodule
`default_nettype wire
